// file: verilog/regulator_wakeup_sequencer.sv
`timescale 1ns/1ps

module regulator_wakeup_sequencer #(
    parameter int STARTUP_COUNT = regulator_wakeup_pkg::STARTUP_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       regulator_enable_strap,
    input  wire logic       regulator_standby_select,
    input  wire logic [1:0] wakeup_time_select,
    input  wire logic       sleep_request,
    input  wire logic       wake_event,
    input  wire logic       level_falling,
    input  wire logic       supply_too_low,
    input  wire logic       low_voltage_flag_clear,
    output logic            regulator_on,
    output logic            core_run,
    output logic            brown_out_reset,
    output logic            low_voltage_detect_flag
);

    // ------------------------------------------------------------
    // Interval selection
    // ------------------------------------------------------------
    localparam int CW = regulator_wakeup_pkg::COUNT_WIDTH;

    function automatic logic [CW-1:0] wake_len(input logic standby, input logic [1:0] sel);
        logic [CW-1:0] v;
        v = CW'(regulator_wakeup_pkg::WAKE_SEL0_CYCLES);
        if (standby) begin
            v = CW'(regulator_wakeup_pkg::WAKE_STANDBY_CYCLES);
        end else begin
            case (sel)
                2'h0:    v = CW'(regulator_wakeup_pkg::WAKE_SEL0_CYCLES);
                2'h1:    v = CW'(regulator_wakeup_pkg::WAKE_SEL1_CYCLES);
                2'h2:    v = CW'(regulator_wakeup_pkg::WAKE_SEL2_CYCLES);
                default: v = CW'(regulator_wakeup_pkg::WAKE_SEL3_CYCLES);
            endcase
        end
        return v;
    endfunction

    regulator_wakeup_pkg::seq_state_type state;
    regulator_wakeup_pkg::seq_state_type next_state;
    logic [CW-1:0]                       count;
    logic [CW-1:0]                       next_count;

    // Power-on uses the full start-up time; wake from sleep uses the selected length.
    wire logic [CW-1:0] power_on_len = CW'(STARTUP_COUNT);
    wire logic [CW-1:0] wake_length  = wake_len(regulator_standby_select, wakeup_time_select);
    wire logic          count_done   = (count <= 16'h0001);
    wire logic          next_run     = (next_state == regulator_wakeup_pkg::st_run);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_count = count;
        case (state)
            regulator_wakeup_pkg::st_off: begin
                if (regulator_enable_strap && !supply_too_low) begin
                    next_state = regulator_wakeup_pkg::st_startup;
                    next_count = power_on_len;
                end
            end
            regulator_wakeup_pkg::st_startup: begin
                if (count_done) begin
                    next_state = regulator_wakeup_pkg::st_run;
                end else begin
                    next_count = count - 16'h0001;
                end
            end
            regulator_wakeup_pkg::st_run: begin
                if (sleep_request) begin
                    next_state = regulator_wakeup_pkg::st_sleep;
                end
            end
            regulator_wakeup_pkg::st_sleep: begin
                if (wake_event) begin
                    next_state = regulator_wakeup_pkg::st_startup;
                    next_count = wake_length;
                end
            end
            default: begin
                next_state = regulator_wakeup_pkg::st_off;
            end
        endcase
        // Brown-out or strap removal drops the sequencer back to st_off and clears the count.
        if (supply_too_low || !regulator_enable_strap) begin
            next_state = regulator_wakeup_pkg::st_off;
            next_count = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state <= regulator_wakeup_pkg::st_off;
            count <= '0;
        end else begin
            state <= next_state;
            count <= next_count;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // The flag never gates core_run, so software can run its shutdown code.
    wire logic next_flag = level_falling | (low_voltage_detect_flag & ~low_voltage_flag_clear);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            core_run                <= regulator_wakeup_pkg::RUN_RESET;
            regulator_on            <= 1'b0;
            brown_out_reset         <= 1'b0;
            low_voltage_detect_flag <= regulator_wakeup_pkg::LVD_FLAG_RESET;
        end else begin
            core_run                <= next_run;
            regulator_on            <= regulator_enable_strap;
            brown_out_reset         <= supply_too_low;
            low_voltage_detect_flag <= next_flag;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    no_run_startup_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state == regulator_wakeup_pkg::st_startup && !count_done) |=> !core_run)
        else $error("Core ran during start-up interval.");

    poweron_len_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state == regulator_wakeup_pkg::st_off && next_state == regulator_wakeup_pkg::st_startup)
        |=> (count == power_on_len))
        else $error("Power-on interval not loaded.");

    wake_restart_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state == regulator_wakeup_pkg::st_sleep && wake_event && regulator_enable_strap && !supply_too_low)
        |=> (state == regulator_wakeup_pkg::st_startup))
        else $error("Wake skipped the start-up interval.");

    wake_length_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state == regulator_wakeup_pkg::st_sleep && next_state == regulator_wakeup_pkg::st_startup)
        |=> (count == $past(wake_length)))
        else $error("Wake interval length wrong.");

    lvd_set_a: assert property (@(posedge clk) disable iff (!reset_n)
        level_falling |=> low_voltage_detect_flag)
        else $error("Low-voltage flag not set.");

    lvd_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (low_voltage_detect_flag && !low_voltage_flag_clear) |=> low_voltage_detect_flag)
        else $error("Low-voltage flag dropped without clear.");

    brownout_a: assert property (@(posedge clk) disable iff (!reset_n)
        supply_too_low |=> (brown_out_reset && !core_run))
        else $error("Brown-out reset missing.");

    strap_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        !regulator_enable_strap |=> (!regulator_on && !core_run))
        else $error("Regulator on without strap.");

    // ------------------------------------------------------------
    // Check helpers
    // ------------------------------------------------------------
    // Counting halted cycles lets a check see the whole interval, not one step of it.
    logic [CW-1:0] halt_cycles;
    logic [CW-1:0] halt_target;
    wire logic     entering_startup = (next_state == regulator_wakeup_pkg::st_startup) &&
                                      (state != regulator_wakeup_pkg::st_startup);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            halt_cycles <= '0;
            halt_target <= '0;
        end else if (entering_startup) begin
            halt_cycles <= 16'h0001;
            halt_target <= next_count;
        end else begin
            halt_cycles <= halt_cycles + 16'h0001;
            halt_target <= halt_target;
        end
    end

    interval_total_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state == regulator_wakeup_pkg::st_startup && next_state == regulator_wakeup_pkg::st_run)
        |-> (halt_cycles == halt_target))
        else $error("Start-up interval length wrong.");

    count_step_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state == regulator_wakeup_pkg::st_startup && !count_done && regulator_enable_strap && !supply_too_low)
        |=> (count == $past(count) - 16'h0001))
        else $error("Start-up count did not step.");

    run_release_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state == regulator_wakeup_pkg::st_startup && count_done && regulator_enable_strap && !supply_too_low)
        |=> core_run)
        else $error("Core not released after interval.");

    sleep_halt_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state == regulator_wakeup_pkg::st_run && sleep_request && regulator_enable_strap && !supply_too_low)
        |=> (state == regulator_wakeup_pkg::st_sleep && !core_run))
        else $error("Sleep did not halt the core.");

    sleep_stay_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state == regulator_wakeup_pkg::st_sleep && !wake_event) |=> !core_run)
        else $error("Core ran while asleep.");

    strap_start_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state == regulator_wakeup_pkg::st_off && regulator_enable_strap && !supply_too_low)
        |=> (state == regulator_wakeup_pkg::st_startup))
        else $error("Strap did not start the regulator.");

    strap_on_a: assert property (@(posedge clk) disable iff (!reset_n)
        regulator_enable_strap |=> regulator_on)
        else $error("Regulator off with strap tied.");

    bor_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        !supply_too_low |=> !brown_out_reset)
        else $error("Brown-out reset without low supply.");

    lvd_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
        (low_voltage_detect_flag && low_voltage_flag_clear && !level_falling) |=> !low_voltage_detect_flag)
        else $error("Low-voltage flag not cleared.");

    lvd_run_a: assert property (@(posedge clk) disable iff (!reset_n)
        (core_run && low_voltage_detect_flag && !sleep_request && regulator_enable_strap && !supply_too_low)
        |=> core_run)
        else $error("Low-voltage flag stopped the core.");

endmodule

// file: verilog/regulator_wakeup_pkg.sv
package regulator_wakeup_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_NS     = 10;
    localparam int STARTUP_TIME_NS     = 10000;
    localparam int STARTUP_CYCLES      = (STARTUP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam int COUNT_WIDTH         = 16;

    // Wake-up interval per standby and select setting, in cycles.
    localparam int WAKE_STANDBY_CYCLES = STARTUP_CYCLES;
    localparam int WAKE_SEL0_CYCLES    = 200;
    localparam int WAKE_SEL1_CYCLES    = 100;
    localparam int WAKE_SEL2_CYCLES    = 50;
    localparam int WAKE_SEL3_CYCLES    = 10;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic LVD_FLAG_RESET    = 1'b0;
    localparam logic RUN_RESET         = 1'b0;

    typedef enum logic [1:0] {
        st_off,
        st_startup,
        st_run,
        st_sleep
    } seq_state_type;

endpackage

// file: test/core_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// Gated processor core
// ------------------------------------------------------------
// A halted core cannot execute a sleep instruction, so the request only leaves it while it runs.
module core_model (
    input  wire logic core_run,
    input  wire logic go_sleep,
    output logic      sleep_request
);
    assign sleep_request = go_sleep & core_run;
endmodule

// file: test/tb.sv
`timescale 1ns/1ps

module tb;
    localparam int n = 20;
    localparam int wl[4] = '{regulator_wakeup_pkg::WAKE_SEL0_CYCLES, regulator_wakeup_pkg::WAKE_SEL1_CYCLES,
                             regulator_wakeup_pkg::WAKE_SEL2_CYCLES, regulator_wakeup_pkg::WAKE_SEL3_CYCLES};
    logic clk, reset_n, strap, stby, go_sleep, sleep_req, wake, fall, low, clr, prev_run;
    logic [1:0]  sel;
    logic        reg_on, run, bor, flag;
    logic [31:0] cyc, seed, exp_q[$];
    int          fail_count, num_checks, i, len;

    regulator_wakeup_sequencer #(.STARTUP_COUNT(n)) DUT (.clk(clk), .reset_n(reset_n),
        .regulator_enable_strap(strap), .regulator_standby_select(stby), .wakeup_time_select(sel),
        .sleep_request(sleep_req), .wake_event(wake), .level_falling(fall), .supply_too_low(low),
        .low_voltage_flag_clear(clr), .regulator_on(reg_on), .core_run(run), .brown_out_reset(bor),
        .low_voltage_detect_flag(flag));
    core_model core (.core_run(run), .go_sleep(go_sleep), .sleep_request(sleep_req));

    always #5 clk = ~clk;

    function logic [31:0] xs(input logic [31:0] v);
        logic [31:0] t;
        t  = v ^ (v << 13);
        t  = t ^ (t >> 17);
        xs = t ^ (t << 5);
    endfunction

    task check_cyc(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task check_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task test_done;
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Bounded wait; the longest interval is the standby one.
    task wait_run(input logic v);
        int k;
        k = 0;
        while (run !== v && k < 1100) begin
            @(negedge clk);
            k++;
        end
        check_bit(run, v);
    endtask

    // ------------------------------------------------------------
    // Monitor: each rise of core_run is matched to the oldest note.
    // ------------------------------------------------------------
    always @(negedge clk) begin
        cyc      <= cyc + 1;
        prev_run <= run;
        if (run === 1'b1 && prev_run === 1'b0 && exp_q.size() > 0) check_cyc(cyc, exp_q.pop_front());
        if (cyc == 32'h0000_4e20) begin
            fail_count++;
            test_done;
        end
    end

    initial begin
        clk = 0; reset_n = 0; strap = 0; stby = 0; sel = 0; go_sleep = 0; wake = 0;
        fall = 0; low = 0; clr = 0; prev_run = 0; cyc = 0; seed = 32'h0000_e66b;
        repeat (4) @(posedge clk);
        reset_n <= 1;
        repeat (10) @(negedge clk);
        check_bit(reg_on, 0);
        check_bit(run, 0);
        @(posedge clk);
        strap <= 1;
        exp_q.push_back(cyc + n + 1);
        wait_run(1);
        check_bit(reg_on, 1);
        for (i = 0; i < 7; i++) begin
            seed = xs(seed);
            len  = (i < 4) ? wl[i] : (seed[2] ? regulator_wakeup_pkg::WAKE_STANDBY_CYCLES : wl[seed[1:0]]);
            @(posedge clk);
            sel      <= (i < 4) ? i[1:0] : seed[1:0];
            stby     <= (i < 4) ? 1'b0 : seed[2];
            go_sleep <= 1;
            @(posedge clk);
            go_sleep <= 0;
            wait_run(0);
            repeat (3) @(posedge clk);
            wake <= 1;
            exp_q.push_back(cyc + len + 1);
            @(posedge clk);
            wake <= 0;
            wait_run(1);
        end
        @(posedge clk);
        fall <= 1;
        @(posedge clk);
        fall <= 0;
        @(negedge clk);
        check_bit(flag, 1);
        repeat (5) @(negedge clk);
        check_bit(flag, 1);
        check_bit(run, 1);
        @(posedge clk);
        fall <= 1;
        clr  <= 1;
        @(posedge clk);
        fall <= 0;
        @(negedge clk);
        check_bit(flag, 1);
        @(posedge clk);
        clr <= 0;
        @(negedge clk);
        check_bit(flag, 0);
        @(posedge clk);
        low <= 1;
        @(posedge clk);
        @(negedge clk);
        check_bit(bor, 1);
        check_bit(run, 0);
        @(posedge clk);
        low <= 0;
        exp_q.push_back(cyc + n + 1);
        wait_run(1);
        check_bit(bor, 0);
        @(posedge clk);
        strap <= 0;
        @(posedge clk);
        @(negedge clk);
        check_bit(run, 0);
        check_bit(reg_on, 0);
        check_cyc(exp_q.size(), 32'h0000_0000);
        test_done;
    end
endmodule
